// ==== rtl/pap_fifo.sv ====
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module pap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic [AW:0] fill;
  logic doPush;
  logic doPop;

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  assign fill = wrPtr_ff - rdPtr_ff;
  assign inReady = (fill != DEPTH[AW:0]);
  assign outValid = (fill != '0);
  assign outData = mem_ff[rdPtr_ff[AW-1:0]];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_ff[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end

endmodule

// ==== rtl/pap_map.svh ====
// Offsets, field positions, reset values and counts of the parallel result port
`ifndef PAP_MAP_SVH
`define PAP_MAP_SVH

// --------------------------------------------------------------------------
// Register addresses
// --------------------------------------------------------------------------
`define PAP_REG_EXIT 7'h00
`define PAP_REG_CONFIG 7'h02
`define PAP_REG_DIAG 7'h21
`define PAP_REG_DIGERR 7'h22

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define PAP_CFG_STATUS_BIT 6
`define PAP_DIAG_CRC_BIT 2
`define PAP_CMD_READ_BIT 15

// --------------------------------------------------------------------------
// Reset values, checksum polynomial and counts
// --------------------------------------------------------------------------
`define PAP_REG_RESET 8'h00
`define PAP_CRC_INIT 16'hFFFF
`define PAP_CRC_POLY 16'h1021
`define PAP_PLAIN_WORDS 5'h08
`define PAP_STATUS_WORDS 5'h10
`define PAP_FIFO_DEPTH 8

`endif

// ==== rtl/pap_pkg.sv ====
// Types shared by the parallel result port
package pap_pkg;

  typedef logic [15:0] pap_word_type;

  typedef enum logic [0:0] {
    PAP_CONV = 1'b0,
    PAP_REG = 1'b1
  } pap_mode_type;

endpackage

// ==== rtl/pap_port.sv ====
// Parallel host port: conversion results, status frames, checksum, register access
`timescale 1ns/1ps
`include "pap_map.svh"
module pap_port #(
  parameter int REG_COUNT = 128,
  parameter int FIFO_DEPTH = `PAP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire pap_pkg::pap_word_type busIn,
  output pap_pkg::pap_word_type busOut,
  output logic busOe,
  output logic markOut,
  output logic markOe,
  input wire logic [2:0] osPins,
  input wire logic convActive,
  input wire logic [127:0] chanData,
  input wire logic resetDetect,
  input wire logic [7:0] digErrBits,
  input wire logic [7:0] openFlags,
  input wire logic [7:0] overFlags,
  input wire logic [7:0] underFlags,
  output logic regModeOut,
  output logic writeDropped
);
  import pap_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [21:0] syncA_ff;
  logic [21:0] syncB_ff;
  logic rdPrev_ff;
  logic wrPrev_ff;
  logic busyPrev_ff;
  pap_word_type chanShadow_ff [0:7];
  logic [7:0] openShadow_ff;
  logic [7:0] overShadow_ff;
  logic [7:0] underShadow_ff;
  logic [7:0] regFile_ff [0:REG_COUNT-1];
  logic [6:0] regAddr_ff;
  pap_mode_type mode_ff;
  logic [4:0] seqIdx_ff;
  pap_word_type crc_ff;
  pap_word_type busOut_ff;
  logic busOe_ff;
  logic markOut_ff;
  logic markOe_ff;
  logic writeDropped_ff;
  logic [4:0] nxt_seqIdx;
  pap_word_type nxt_crc;

  pap_word_type busSync;
  logic csLow;
  logic rdLow;
  logic wrHigh;
  logic swMode;
  logic rdFall;
  logic wrRise;
  logic busyFall;
  logic rdStrobe;
  logic convRead;
  logic statusOn;
  logic crcOn;
  logic [4:0] dataWords;
  logic [4:0] endIdx;
  logic [2:0] chanSel;
  logic isStatus;
  logic isCrc;
  logic [7:0] statusHdr;
  pap_word_type resultWord;
  pap_word_type convWord;
  pap_word_type regWord;
  logic [7:0] regData;
  logic fifoInReady;
  pap_word_type fifoData;
  logic fifoValid;
  logic drainReady;
  logic popFire;
  logic popRead;
  logic [6:0] popAddr;
  logic [7:0] popData;

  function automatic pap_word_type crcStep(input pap_word_type c, input pap_word_type w);
    pap_word_type r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ `PAP_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  // Bus data rides through the same two stages as the write strobe, so the
  // word seen at the synced strobe rise is the word the host held at its edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_ff <= 22'h3F0000;
      syncB_ff <= 22'h3F0000;
    end else begin
      syncA_ff <= {osPins, wrN, rdN, csN, busIn};
      syncB_ff <= syncA_ff;
    end
  end

  assign busSync = syncB_ff[15:0];
  assign csLow = ~syncB_ff[16];
  assign rdLow = ~syncB_ff[17];
  assign wrHigh = syncB_ff[18];
  assign swMode = &syncB_ff[21:19];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdPrev_ff <= 1'b0;
      wrPrev_ff <= 1'b1;
      busyPrev_ff <= 1'b0;
    end else begin
      rdPrev_ff <= rdLow;
      wrPrev_ff <= wrHigh;
      busyPrev_ff <= convActive;
    end
  end

  assign rdFall = rdLow & ~rdPrev_ff;
  assign wrRise = wrHigh & ~wrPrev_ff;
  assign busyFall = busyPrev_ff & ~convActive;
  // Joined select/read and select held low both land here
  assign rdStrobe = rdFall & csLow;
  assign convRead = rdStrobe & (mode_ff == PAP_CONV);

  // --------------------------------------------------------------------------
  // Result shadow, loaded only on the conversion-active fall
  // --------------------------------------------------------------------------
  // Reads while busy see the old set until this edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        chanShadow_ff[i] <= 16'h0000;
      end
      openShadow_ff <= 8'h00;
      overShadow_ff <= 8'h00;
      underShadow_ff <= 8'h00;
    end else if (busyFall) begin
      for (int i = 0; i < 8; i++) begin
        chanShadow_ff[i] <= chanData[i*16 +: 16];
      end
      openShadow_ff <= openFlags;
      overShadow_ff <= overFlags;
      underShadow_ff <= underFlags;
    end
  end

  // --------------------------------------------------------------------------
  // Word selection for conversion reads
  // --------------------------------------------------------------------------
  assign statusOn = swMode & regFile_ff[`PAP_REG_CONFIG][`PAP_CFG_STATUS_BIT];
  assign crcOn = swMode & regFile_ff[`PAP_REG_DIAG][`PAP_DIAG_CRC_BIT];
  assign dataWords = statusOn ? `PAP_STATUS_WORDS : `PAP_PLAIN_WORDS;
  assign endIdx = crcOn ? dataWords : dataWords - 5'h01;
  assign chanSel = statusOn ? seqIdx_ff[3:1] : seqIdx_ff[2:0];
  assign isStatus = statusOn & seqIdx_ff[0];
  assign isCrc = crcOn & (seqIdx_ff == dataWords);
  assign statusHdr = {resetDetect, |digErrBits, openShadow_ff[chanSel],
                      overShadow_ff[chanSel], underShadow_ff[chanSel], chanSel};
  assign resultWord = chanShadow_ff[chanSel];
  assign convWord = isCrc ? crc_ff : (isStatus ? {statusHdr, 8'h00} : resultWord);

  // --------------------------------------------------------------------------
  // Register read word
  // --------------------------------------------------------------------------
  // The error register mirrors live flags; software cannot overwrite it
  assign regData = (regAddr_ff == `PAP_REG_DIGERR) ? digErrBits : regFile_ff[regAddr_ff];
  assign regWord = {1'b0, regAddr_ff, regData};

  // --------------------------------------------------------------------------
  // Sequence pointer and checksum
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_seqIdx = seqIdx_ff;
    nxt_crc = crc_ff;
    if (busyFall) begin
      nxt_seqIdx = 5'h00;
    end else if (convRead) begin
      nxt_seqIdx = (seqIdx_ff >= endIdx) ? 5'h00 : seqIdx_ff + 5'h01;
      if (!isCrc) begin
        nxt_crc = crcStep((seqIdx_ff == 5'h00) ? `PAP_CRC_INIT : crc_ff, convWord);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seqIdx_ff <= 5'h00;
      crc_ff <= `PAP_CRC_INIT;
    end else begin
      seqIdx_ff <= nxt_seqIdx;
      crc_ff <= nxt_crc;
    end
  end

  // --------------------------------------------------------------------------
  // Bus and marker outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busOut_ff <= 16'h0000;
      busOe_ff <= 1'b0;
      markOut_ff <= 1'b0;
      markOe_ff <= 1'b0;
    end else begin
      busOe_ff <= csLow & rdLow;
      markOe_ff <= csLow;
      if (rdStrobe) begin
        // Register mode never shows results
        busOut_ff <= (mode_ff == PAP_REG) ? regWord : convWord;
        markOut_ff <= (mode_ff == PAP_CONV) & (seqIdx_ff == 5'h00);
      end
    end
  end

  assign busOut = busOut_ff;
  assign busOe = busOe_ff;
  assign markOut = markOut_ff;
  assign markOe = markOe_ff;

  // --------------------------------------------------------------------------
  // Write frame FIFO
  // --------------------------------------------------------------------------
  // Frames are applied only between reads so a config change never lands
  // inside a word being driven. Frames arriving with the FIFO full are lost.
  assign drainReady = ~(csLow & rdLow);
  assign popFire = fifoValid & drainReady;

  pap_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_frames (
    .clk(clk),
    .resetn(resetn),
    .inData(busSync),
    .inValid(wrRise & csLow),
    .inReady(fifoInReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(drainReady)
  );

  assign popRead = fifoData[`PAP_CMD_READ_BIT];
  assign popAddr = fifoData[14:8];
  assign popData = fifoData[7:0];

  // --------------------------------------------------------------------------
  // Command decode and register file
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= PAP_CONV;
      regAddr_ff <= 7'h00;
      writeDropped_ff <= 1'b0;
    end else begin
      writeDropped_ff <= wrRise & csLow & ~fifoInReady;
      if (popFire && swMode) begin
        if (popRead) begin
          regAddr_ff <= popAddr;
          mode_ff <= PAP_REG;
        end else if (popAddr == `PAP_REG_EXIT) begin
          mode_ff <= PAP_CONV;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile_ff[i] <= `PAP_REG_RESET;
      end
    end else if (popFire && swMode && !popRead && popAddr != `PAP_REG_EXIT) begin
      regFile_ff[popAddr] <= popData;
    end
  end

  assign regModeOut = (mode_ff == PAP_REG);
  assign writeDropped = writeDropped_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_readFrame;
    rdFall && csLow;
  endsequence

  sequence s_convFrame;
    s_readFrame ##0 (mode_ff == PAP_CONV);
  endsequence

  a_bus_drive: assert property (@(posedge clk) disable iff (!resetn)
    (csLow && rdLow) |=> busOe_ff)
    else $error("bus not driven with select and read low");

  a_bus_release: assert property (@(posedge clk) disable iff (!resetn)
    $rose(syncB_ff[16]) |=> !busOe_ff ##1 !busOe_ff [*1] or !csLow)
    else $error("bus not released after select rise");

  a_marker_float: assert property (@(posedge clk) disable iff (!resetn)
    !csLow |=> !markOe_ff)
    else $error("marker driven while select high");

  a_first_word: assert property (@(posedge clk) disable iff (!resetn)
    (s_convFrame ##0 (seqIdx_ff == 5'h00) ##0 !isCrc)
      |=> markOut_ff && busOut_ff == $past(chanShadow_ff[0]))
    else $error("first frame is not channel one with marker");

  a_marker_drop: assert property (@(posedge clk) disable iff (!resetn)
    (s_readFrame ##0 (mode_ff == PAP_REG || seqIdx_ff != 5'h00)) |=> !markOut_ff)
    else $error("marker still high after next read");

  a_ptr_restart: assert property (@(posedge clk) disable iff (!resetn)
    busyFall |=> seqIdx_ff == 5'h00)
    else $error("pointer not restarted on result load");

  a_load_edge: assert property (@(posedge clk) disable iff (!resetn)
    busyFall |=> chanShadow_ff[7] == $past(chanData[127:112]))
    else $error("results not loaded on conversion fall");

  a_hold_busy: assert property (@(posedge clk) disable iff (!resetn)
    (convActive && !busyFall) |=> $stable(chanShadow_ff[0]))
    else $error("results changed outside conversion fall");

  a_status_zero: assert property (@(posedge clk) disable iff (!resetn)
    (s_convFrame ##0 (isStatus && !isCrc)) |=> busOut_ff[7:0] == 8'h00
      && busOut_ff[10:8] == $past(chanSel))
    else $error("status frame lower byte or index wrong");

  a_reg_frame: assert property (@(posedge clk) disable iff (!resetn)
    (s_readFrame ##0 (mode_ff == PAP_REG))
      |=> !busOut_ff[15] && busOut_ff[14:8] == $past(regAddr_ff))
    else $error("register frame layout wrong");

  a_read_cmd: assert property (@(posedge clk) disable iff (!resetn)
    (popFire && swMode && popRead) |=> mode_ff == PAP_REG && regAddr_ff == $past(popAddr))
    else $error("read command not taken");

  a_exit_write: assert property (@(posedge clk) disable iff (!resetn)
    (popFire && swMode && !popRead && popAddr == `PAP_REG_EXIT) |=> mode_ff == PAP_CONV)
    else $error("write to address zero did not exit register mode");

  a_hw_mode: assert property (@(posedge clk) disable iff (!resetn)
    (popFire && !swMode) |=> $stable(mode_ff) && $stable(regFile_ff[`PAP_REG_CONFIG])
      && $stable(regFile_ff[`PAP_REG_DIAG]))
    else $error("extra features active outside software mode");

endmodule

// ==== sim/pap_host_model.sv ====
// Host pin model: select, read and write strobes, shared bus level
`timescale 1ns/1ps
module pap_host_model (
  input wire logic clk,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output pap_pkg::pap_word_type busIn,
  input wire pap_pkg::pap_word_type busOut,
  input wire logic busOe,
  input wire logic markOut
);
  import pap_pkg::*;
  // --------------------------------------------------------------------------
  // Bus level
  // --------------------------------------------------------------------------
  logic csTied = 1'b0;
  logic hostDrv = 1'b0;
  pap_word_type hostData = 16'h0000;
  pap_word_type idlePat = 16'h5AA5;
  // Undriven bus moves every cycle so a stale value can never pass
  always @(posedge clk) idlePat <= ~idlePat;
  // Host wins a clash; only the buffer test drives both at once
  assign busIn = hostDrv ? hostData : (busOe ? busOut : idlePat);
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
  end
  // --------------------------------------------------------------------------
  // Transfers; every strobe level lasts 4 cycles, one more than the sync needs
  // --------------------------------------------------------------------------
  task automatic hostRead(output pap_word_type word, output logic oe, output logic mark);
    @(posedge clk);
    csN <= 1'b0;
    rdN <= 1'b0;
    repeat (4) @(posedge clk);
    word = busOut;
    oe = busOe;
    mark = markOut;
    rdN <= 1'b1;
    csN <= ~csTied;
    repeat (4) @(posedge clk);
  endtask
  task automatic hostWrite(input pap_word_type w);
    @(posedge clk);
    hostDrv <= 1'b1;
    hostData <= w;
    csN <= 1'b0;
    wrN <= 1'b0;
    repeat (4) @(posedge clk);
    wrN <= 1'b1;
    repeat (4) @(posedge clk);
    hostDrv <= 1'b0;
    csN <= ~csTied;
    repeat (4) @(posedge clk);
  endtask
  task automatic hostHold(input logic low);
    @(posedge clk);
    rdN <= ~low;
    csN <= ~(low | csTied);
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== sim/tb_top.sv ====
// Bench: result reads, status and checksum, register access, write buffer
`timescale 1ns/1ps
`include "pap_map.svh"
module tb_top;
  import pap_pkg::*;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] osPins = 3'b111;
  logic convActive = 1'b0;
  logic [127:0] chanData = 128'h0;
  logic resetDetect = 1'b0;
  logic [7:0] digErrBits = 8'h00;
  logic [7:0] openFlags = 8'h00;
  logic [7:0] overFlags = 8'h00;
  logic [7:0] underFlags = 8'h00;
  logic csN, rdN, wrN, busOe, markOut, markOe, regModeOut, writeDropped, oe, mk;
  pap_word_type busIn, busOut, w;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int dropCount = 0;
  initial begin
    forever #2 clk = ~clk;
  end
  pap_port pap_port_inst (.clk(clk), .resetn(resetn), .csN(csN), .rdN(rdN), .wrN(wrN),
    .busIn(busIn), .busOut(busOut), .busOe(busOe), .markOut(markOut), .markOe(markOe),
    .osPins(osPins), .convActive(convActive), .chanData(chanData),
    .resetDetect(resetDetect), .digErrBits(digErrBits), .openFlags(openFlags),
    .overFlags(overFlags), .underFlags(underFlags), .regModeOut(regModeOut),
    .writeDropped(writeDropped));
  pap_host_model pap_host_model_inst (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN),
    .busIn(busIn), .busOut(busOut), .busOe(busOe), .markOut(markOut));
  // The whole run needs about 940 cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (writeDropped === 1'b1) dropCount = dropCount + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic checkWord(input string what, input pap_word_type exp, input pap_word_type got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic endTest(input string name);
    $display("Test %s finished", name);
  endtask
  function automatic pap_word_type crcStep(input pap_word_type c, input pap_word_type d);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? `PAP_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  function automatic logic [7:0] hdrByte(input int ch);
    return {resetDetect, |digErrBits, openFlags[ch], overFlags[ch], underFlags[ch], 3'(ch)};
  endfunction
  task automatic setData(input pap_word_type base);
    for (int k = 0; k < 8; k++) chanData[16*k +: 16] <= base + 16'(k);
  endtask
  task automatic convert(input pap_word_type base);
    @(posedge clk);
    convActive <= 1'b1;
    setData(base);
    repeat (4) @(posedge clk);
    convActive <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic readSeq(input pap_word_type base, input logic stat, input logic crc);
    pap_word_type rw;
    pap_word_type expW;
    pap_word_type sum;
    logic roe;
    logic rmk;
    int n;
    sum = `PAP_CRC_INIT;
    n = stat ? 16 : 8;
    for (int i = 0; i < n + int'(crc); i++) begin
      if (i == n) expW = sum;
      else if (stat && i[0]) expW = {hdrByte(i / 2), 8'h00};
      else expW = base + 16'(stat ? i / 2 : i);
      sum = crcStep(sum, expW);
      pap_host_model_inst.hostRead(rw, roe, rmk);
      checkWord("bus word", expW, rw);
      checkBit("bus enable", 1'b1, roe);
      checkBit("first marker", i == 0, rmk);
    end
  endtask
  task automatic regWrite(input logic [6:0] addr, input logic [7:0] data);
    pap_host_model_inst.hostWrite({1'b0, addr, data});
  endtask
  task automatic regRead(input logic [6:0] addr, input logic [7:0] exp);
    pap_word_type rw;
    logic roe;
    logic rmk;
    pap_host_model_inst.hostWrite({1'b1, addr, 8'h00});
    pap_host_model_inst.hostRead(rw, roe, rmk);
    checkWord("register frame", {1'b0, addr, exp}, rw);
  endtask
  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    checkBit("bus enable at reset", 1'b0, busOe);
    checkBit("marker enable at reset", 1'b0, markOe);
    checkBit("mode at reset", 1'b0, regModeOut);
    endTest("reset");
    convert(16'h1100);
    readSeq(16'h1100, 1'b0, 1'b0);
    @(posedge clk);
    checkBit("marker enable, select high", 1'b0, markOe);
    checkBit("bus enable, select high", 1'b0, busOe);
    endTest("plain results");
    @(posedge clk);
    convActive <= 1'b1;
    setData(16'h2200);
    pap_host_model_inst.hostRead(w, oe, mk);
    checkWord("old word one", 16'h1100, w);
    pap_host_model_inst.hostRead(w, oe, mk);
    checkWord("old word two", 16'h1101, w);
    convActive <= 1'b0;
    repeat (4) @(posedge clk);
    readSeq(16'h2200, 1'b0, 1'b0);
    endTest("read during conversion");
    pap_host_model_inst.csTied = 1'b1;
    convert(16'hB300);
    readSeq(16'hB300, 1'b0, 1'b0);
    checkBit("marker enable, select held", 1'b1, markOe);
    pap_host_model_inst.csTied = 1'b0;
    endTest("select held low");
    digErrBits <= 8'h24;
    regWrite(7'h05, 8'h5A);
    checkBit("mode after single write", 1'b0, regModeOut);
    regRead(7'h05, 8'h5A);
    checkBit("mode after read command", 1'b1, regModeOut);
    regRead(`PAP_REG_DIGERR, 8'h24);
    pap_host_model_inst.hostRead(w, oe, mk);
    checkWord("no result in register mode", {1'b0, `PAP_REG_DIGERR, 8'h24}, w);
    regWrite(`PAP_REG_CONFIG, 8'h40);
    regWrite(`PAP_REG_DIAG, 8'h04);
    regWrite(`PAP_REG_EXIT, 8'h00);
    checkBit("mode after exit write", 1'b0, regModeOut);
    endTest("register access");
    resetDetect <= 1'b1;
    openFlags <= 8'h81;
    overFlags <= 8'h42;
    underFlags <= 8'h24;
    convert(16'h4400);
    readSeq(16'h4400, 1'b1, 1'b1);
    endTest("status and checksum");
    osPins <= 3'b011;
    regWrite(`PAP_REG_CONFIG, 8'h00);
    osPins <= 3'b111;
    repeat (4) @(posedge clk);
    convert(16'h5500);
    readSeq(16'h5500, 1'b1, 1'b1);
    endTest("write outside software mode");
    regRead(7'h10, 8'h00);
    pap_host_model_inst.csTied = 1'b1;
    pap_host_model_inst.hostHold(1'b1);
    for (int i = 0; i < 9; i++) regWrite(7'h10 + 7'(i), 8'hA0 + 8'(i));
    checkWord("dropped frames", 16'h0001, 16'(dropCount));
    pap_host_model_inst.hostHold(1'b0);
    pap_host_model_inst.csTied = 1'b0;
    regRead(7'h10, 8'hA0);
    regRead(7'h17, 8'hA7);
    regRead(7'h18, 8'h00);
    regWrite(`PAP_REG_EXIT, 8'h00);
    endTest("write buffer");
    report_and_stop();
  end
endmodule
